/* File: ftc_defines.svh */
/*
  Offsets, reset values and bank limits of the fan and thermal
  configuration bank. Holds definitions only and assumes nothing of the
  files that include it.
*/
`ifndef FTC_DEFINES_SVH
`define FTC_DEFINES_SVH

// Bank limits
`define FTC_BASE 8'h5a
`define FTC_LAST 8'h80
`define FTC_NREG 39

// Register offsets
`define FTC_FAN4_MIN_LO 8'h5a
`define FTC_FAN4_MIN_HI 8'h5b
`define FTC_DRV1_CFG 8'h5c
`define FTC_DRV2_CFG 8'h5d
`define FTC_DRV3_CFG 8'h5e
`define FTC_R1_RANGE 8'h5f
`define FTC_LOC_RANGE 8'h60
`define FTC_R2_RANGE 8'h61
`define FTC_SMOOTH1 8'h62
`define FTC_SMOOTH2 8'h63
`define FTC_DRV1_MIN 8'h64
`define FTC_DRV2_MIN 8'h65
`define FTC_DRV3_MIN 8'h66
`define FTC_R1_START 8'h67
`define FTC_LOC_START 8'h68
`define FTC_R2_START 8'h69
`define FTC_R1_OT 8'h6a
`define FTC_LOC_OT 8'h6b
`define FTC_R2_OT 8'h6c
`define FTC_R1L_HYST 8'h6d
`define FTC_R2_HYST 8'h6e
`define FTC_TREE_TEST 8'h6f
`define FTC_R1_OFS 8'h70
`define FTC_LOC_OFS 8'h71
`define FTC_R2_OFS 8'h72
`define FTC_CFG2 8'h73
`define FTC_MASK1 8'h74
`define FTC_MASK2 8'h75
`define FTC_SUP_LSB 8'h76
`define FTC_TMP_LSB 8'h77
`define FTC_CFG3 8'h78
`define FTC_OT_STAT 8'h79
`define FTC_OT_LIM 8'h7a
`define FTC_PULSES 8'h7b
`define FTC_CFG5 8'h7c
`define FTC_CFG4 8'h7d
`define FTC_TEST1 8'h7e
`define FTC_TEST2 8'h7f
`define FTC_TEST3 8'h80

// Reset values
`define FTC_RST_ONES 8'hff
`define FTC_RST_ZERO 8'h00
`define FTC_RST_DRV_CFG 8'h82
`define FTC_RST_RANGE 8'hcc
`define FTC_RST_MIN 8'h80
`define FTC_RST_START 8'h9a
`define FTC_RST_OT 8'ha4
`define FTC_RST_R1L_HYST 8'h44
`define FTC_RST_R2_HYST 8'h40
`define FTC_RST_PULSES 8'h55
`define FTC_RST_TEST3 8'h10

// Writable bit masks
`define FTC_WM_ALL 8'hff
`define FTC_WM_HI_NIB 8'hf0
`define FTC_WM_BIT0 8'h01
`define FTC_WM_MASK1 8'hf6
`define FTC_WM_MASK2 8'hfe
`define FTC_WM_CFG4 8'h3f

`endif

/* File: ftc_pkg.sv */
/*
  Types shared by the fan and thermal configuration bank.
  Assumes nothing of its surroundings.
*/
package ftc_pkg;
  typedef logic [7:0] ftc_byte_t;
  typedef logic [7:0] ftc_addr_t;
endpackage

/* File: ftc_regs.sv */
/*
  Fan and thermal configuration register bank, offsets 0x5a to 0x80,
  reached through a plain strobe port with read data one cycle later.
  Assumes the lock bit, the reading low bits and the overtemperature
  timer state come from logic on the same clock.
*/
// Strobed register access is this design's own decision.
// Summary of operation
// - Fan 4 speed minimum split low/high, all ones
// - Drive config: behaviour, invert, slow, spin-up; lockable
// - Range/frequency registers reset 0xcc, lockable
// - Smoothing register one fields, resets zero
// - Smoothing register two fields, resets zero
// - Three minimum duty registers reset 0x80
// - Three fan start temperatures reset 0x9a
// - Overtemperature limits reset 0xa4, third variant
// - Hysteresis nibbles reset 0x44 and 0x40
// - Logic tree test enable bit zero only
// - Three temperature offsets reset zero, lockable
// - Configuration two fields, resets zero
// - Event mask one, bits 3 and 0 reserved
// - Event mask two, bit 0 reserved
// - Read-only extended resolution low bits
// - Configuration three fields, resets zero
// - Read-only overtemperature timer and flag
// - Timer limit writable, not lockable, zero
// - Pulses per revolution two bits per fan
// - Configuration five fields, variant reset
// - Configuration four fields, resets zero
// - Lock bit makes lockable registers read-only
`timescale 1ns/100ps
`include "ftc_defines.svh"

module ftc_regs #(
  parameter logic [7:0] DRV_CFG_RST = `FTC_RST_DRV_CFG,
  parameter logic [7:0] R2_OT_RST = `FTC_RST_OT,
  parameter logic [7:0] CFG5_RST = `FTC_RST_ZERO
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire ftc_pkg::ftc_addr_t addr,
  input wire ftc_pkg::ftc_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output ftc_pkg::ftc_byte_t rdata,
  input wire logic lock_bit,
  input wire logic [1:0] main_supply_lsbs,
  input wire logic [1:0] processor_supply,
  input wire logic [1:0] remote2_lsbs,
  input wire logic [1:0] local_lsbs,
  input wire logic [1:0] remote1_lsbs,
  input wire logic [6:0] elapsed_timer,
  input wire logic asserted_timeout_flag,
  output logic [15:0] fan4_speed_min,
  output ftc_pkg::ftc_byte_t fan_drive1_config,
  output ftc_pkg::ftc_byte_t fan_drive2_config,
  output ftc_pkg::ftc_byte_t fan_drive3_config,
  output ftc_pkg::ftc_byte_t remote1_range_drive_drive_code_a,
  output ftc_pkg::ftc_byte_t local_range_drive_drive_code_a,
  output ftc_pkg::ftc_byte_t remote2_range_drive_drive_code_a,
  output ftc_pkg::ftc_byte_t acoustic_smoothing_1,
  output ftc_pkg::ftc_byte_t acoustic_smoothing_2,
  output ftc_pkg::ftc_byte_t drive1_min_duty,
  output ftc_pkg::ftc_byte_t drive2_min_duty,
  output ftc_pkg::ftc_byte_t drive3_min_duty,
  output ftc_pkg::ftc_byte_t remote1_fan_start_temp,
  output ftc_pkg::ftc_byte_t local_fan_start_temp,
  output ftc_pkg::ftc_byte_t remote2_fan_start_temp,
  output ftc_pkg::ftc_byte_t remote1_overtemp_limit,
  output ftc_pkg::ftc_byte_t local_overtemp_limit,
  output ftc_pkg::ftc_byte_t remote2_overtemp_limit,
  output logic [3:0] remote1_hyst,
  output logic [3:0] local_hyst,
  output logic [3:0] remote2_hyst,
  output logic logic_tree_test_on,
  output ftc_pkg::ftc_byte_t remote1_temp_offset,
  output ftc_pkg::ftc_byte_t local_temp_offset,
  output ftc_pkg::ftc_byte_t remote2_temp_offset,
  output ftc_pkg::ftc_byte_t config_two,
  output ftc_pkg::ftc_byte_t event_mask_one,
  output ftc_pkg::ftc_byte_t event_mask_two,
  output ftc_pkg::ftc_byte_t config_three,
  output ftc_pkg::ftc_byte_t overtemp_timer_limit,
  output ftc_pkg::ftc_byte_t fan_pulses_per_rev,
  output ftc_pkg::ftc_byte_t config_five,
  output ftc_pkg::ftc_byte_t config_four
);
  import ftc_pkg::*;

  // Bits software may change; zero means read-only or reserved
  function automatic ftc_byte_t wmask(input ftc_addr_t a);
    ftc_byte_t m;
    m = `FTC_WM_ALL;
    case (a)
      `FTC_R2_HYST: m = `FTC_WM_HI_NIB;
      `FTC_TREE_TEST: m = `FTC_WM_BIT0;
      `FTC_MASK1: m = `FTC_WM_MASK1;
      `FTC_MASK2: m = `FTC_WM_MASK2;
      `FTC_CFG4: m = `FTC_WM_CFG4;
      `FTC_SUP_LSB, `FTC_TMP_LSB, `FTC_OT_STAT: m = 8'h00;
      `FTC_TEST1, `FTC_TEST2, `FTC_TEST3: m = 8'h00;
      default: m = (a >= `FTC_BASE && a <= `FTC_LAST) ? m : 8'h00;
    endcase
    return m;
  endfunction

  // Registers that the lock bit freezes
  function automatic logic lockable(input ftc_addr_t a);
    logic l;
    l = 1'b0;
    case (a)
      `FTC_CFG3, `FTC_CFG5, `FTC_CFG4: l = 1'b1;
      default: l = (a >= `FTC_DRV1_CFG && a <= `FTC_CFG2);
    endcase
    return l;
  endfunction

  // Reset value of each offset
  function automatic ftc_byte_t rst_val(input ftc_addr_t a);
    ftc_byte_t v;
    v = `FTC_RST_ZERO;
    case (a)
      `FTC_FAN4_MIN_LO, `FTC_FAN4_MIN_HI: v = `FTC_RST_ONES;
      `FTC_DRV1_CFG, `FTC_DRV2_CFG, `FTC_DRV3_CFG: v = DRV_CFG_RST;
      `FTC_R1_RANGE, `FTC_LOC_RANGE, `FTC_R2_RANGE:
        v = `FTC_RST_RANGE;
      `FTC_DRV1_MIN, `FTC_DRV2_MIN, `FTC_DRV3_MIN:
        v = `FTC_RST_MIN;
      `FTC_R1_START, `FTC_LOC_START, `FTC_R2_START:
        v = `FTC_RST_START;
      `FTC_R1_OT, `FTC_LOC_OT: v = `FTC_RST_OT;
      `FTC_R2_OT: v = R2_OT_RST;
      `FTC_R1L_HYST: v = `FTC_RST_R1L_HYST;
      `FTC_R2_HYST: v = `FTC_RST_R2_HYST;
      `FTC_PULSES: v = `FTC_RST_PULSES;
      `FTC_CFG5: v = CFG5_RST;
      `FTC_TEST3: v = `FTC_RST_TEST3;
      default: v = `FTC_RST_ZERO;
    endcase
    return v;
  endfunction

  // Array slot of an offset
  function automatic int ix(input ftc_addr_t a);
    return int'(a - `FTC_BASE);
  endfunction

  ftc_byte_t bank_reg [`FTC_NREG];
  ftc_byte_t bank_next [`FTC_NREG];
  ftc_byte_t rdata_reg;
  ftc_byte_t rd_val;
  ftc_byte_t stored_val;
  logic hit;
  logic locked_hit;
  logic wr_ok;
  logic [5:0] idx;

  // Address decode and write qualification
  assign hit = (addr >= `FTC_BASE) && (addr <= `FTC_LAST);
  assign idx = 6'(addr - `FTC_BASE);
  assign locked_hit = lock_bit && lockable(addr);
  // Locked writes are dropped silently; the bus never stalls
  assign wr_ok = clk_en && wr && hit && !locked_hit;

  // Storage, one byte per offset; masked merge keeps neighbours intact
  for (genvar i = 0; i < `FTC_NREG; i++)
  begin : g_bank
    localparam ftc_addr_t A = 8'(`FTC_BASE + i);
    localparam ftc_byte_t M = wmask(A);
    localparam ftc_byte_t R = rst_val(A);
    logic we;
    assign we = wr_ok && (idx == 6'(i));
    assign bank_next[i] = (bank_reg[i] & ~M) | (wdata & M);
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        bank_reg[i] <= R;
      else if (we)
        bank_reg[i] <= bank_next[i];
    end
  end

  // Read selection; bytes 0x76, 0x77 and 0x79 are live, test bytes stored, reserved bits zero
  assign stored_val = hit ? bank_reg[idx] : 8'h00;
  always_comb
  begin
    rd_val = stored_val;
    case (addr)
      `FTC_SUP_LSB:
        rd_val = {2'b00, main_supply_lsbs, processor_supply,
                  2'b00};
      `FTC_TMP_LSB:
        rd_val = {remote2_lsbs, local_lsbs, remote1_lsbs,
                  2'b00};
      `FTC_OT_STAT:
        rd_val = {elapsed_timer, asserted_timeout_flag};
      default: rd_val = stored_val;
    endcase
  end

  // Read data stand one cycle, zero otherwise
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_reg <= 8'h00;
    else if (clk_en)
      rdata_reg <= rd ? rd_val : 8'h00;
  end
  assign rdata = rdata_reg;

  // Register contents to the fan and measurement logic
  assign fan4_speed_min = {bank_reg[ix(`FTC_FAN4_MIN_HI)],
                           bank_reg[ix(`FTC_FAN4_MIN_LO)]};
  assign fan_drive1_config = bank_reg[ix(`FTC_DRV1_CFG)];
  assign fan_drive2_config = bank_reg[ix(`FTC_DRV2_CFG)];
  assign fan_drive3_config = bank_reg[ix(`FTC_DRV3_CFG)];
  assign remote1_range_drive_drive_code_a = bank_reg[ix(`FTC_R1_RANGE)];
  assign local_range_drive_drive_code_a = bank_reg[ix(`FTC_LOC_RANGE)];
  assign remote2_range_drive_drive_code_a = bank_reg[ix(`FTC_R2_RANGE)];
  assign acoustic_smoothing_1 = bank_reg[ix(`FTC_SMOOTH1)];
  assign acoustic_smoothing_2 = bank_reg[ix(`FTC_SMOOTH2)];
  assign drive1_min_duty = bank_reg[ix(`FTC_DRV1_MIN)];
  assign drive2_min_duty = bank_reg[ix(`FTC_DRV2_MIN)];
  assign drive3_min_duty = bank_reg[ix(`FTC_DRV3_MIN)];
  assign remote1_fan_start_temp = bank_reg[ix(`FTC_R1_START)];
  assign local_fan_start_temp = bank_reg[ix(`FTC_LOC_START)];
  assign remote2_fan_start_temp = bank_reg[ix(`FTC_R2_START)];
  assign remote1_overtemp_limit = bank_reg[ix(`FTC_R1_OT)];
  assign local_overtemp_limit = bank_reg[ix(`FTC_LOC_OT)];
  assign remote2_overtemp_limit = bank_reg[ix(`FTC_R2_OT)];
  assign remote1_hyst = bank_reg[ix(`FTC_R1L_HYST)][7:4];
  assign local_hyst = bank_reg[ix(`FTC_R1L_HYST)][3:0];
  assign remote2_hyst = bank_reg[ix(`FTC_R2_HYST)][7:4];
  assign logic_tree_test_on = bank_reg[ix(`FTC_TREE_TEST)][0];
  assign remote1_temp_offset = bank_reg[ix(`FTC_R1_OFS)];
  assign local_temp_offset = bank_reg[ix(`FTC_LOC_OFS)];
  assign remote2_temp_offset = bank_reg[ix(`FTC_R2_OFS)];
  assign config_two = bank_reg[ix(`FTC_CFG2)];
  assign event_mask_one = bank_reg[ix(`FTC_MASK1)];
  assign event_mask_two = bank_reg[ix(`FTC_MASK2)];
  assign config_three = bank_reg[ix(`FTC_CFG3)];
  assign overtemp_timer_limit = bank_reg[ix(`FTC_OT_LIM)];
  assign fan_pulses_per_rev = bank_reg[ix(`FTC_PULSES)];
  assign config_five = bank_reg[ix(`FTC_CFG5)];
  assign config_four = bank_reg[ix(`FTC_CFG4)];

  // Checks on the bus behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Accepted write reads back masked in the next cycle
  write_back_a: assert property (
    (wr_ok && wmask(addr) != 8'h00
      ##1 clk_en && rd && addr == $past(addr))
      |=> rdata == ($past(wdata, 2) & wmask($past(addr, 2))))
    else $error("write did not read back masked");

  // Locked write leaves the old value
  lock_hold_a: assert property (
    (clk_en && wr && hit && locked_hit
      ##1 clk_en && rd && addr == $past(addr))
      |=> rdata == $past(rd_val, 2))
    else $error("locked register changed");

  // Timer limit ignores the lock
  limit_unlocked_a: assert property (
    (clk_en && wr && addr == `FTC_OT_LIM && lock_bit)
      |=> overtemp_timer_limit == $past(wdata))
    else $error("timer limit write lost");

  // Read data only in the cycle after the strobe
  rdata_idle_a: assert property (
    (clk_en && !rd) |=> rdata == 8'h00)
    else $error("read data outside read slot");

  // Status byte mirrors the timer inputs
  timer_read_a: assert property (
    (clk_en && rd && addr == `FTC_OT_STAT)
      |=> rdata == {$past(elapsed_timer),
                    $past(asserted_timeout_flag)})
    else $error("timer status read wrong");

  // Supply extended resolution byte reserved bits
  lsb_reserved_a: assert property (
    (clk_en && rd && addr == `FTC_SUP_LSB)
      |=> rdata[7:6] == 2'b00 && rdata[1:0] == 2'b00)
    else $error("reserved low bits set");

  // Hysteresis low nibble stays zero
  hyst_reserved_a: assert property (
    (clk_en && rd && addr == `FTC_R2_HYST) |=> rdata[3:0] == 4'h0)
    else $error("reserved nibble set");

  // Third test byte keeps its value
  test_const_a: assert property (
    (clk_en && rd && addr == `FTC_TEST3) |=> rdata == `FTC_RST_TEST3)
    else $error("test register changed");

  // Unmapped reads give zero
  unmapped_zero_a: assert property (
    (clk_en && rd && !hit) |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // Low enable freezes the read port
  freeze_a: assert property (
    !clk_en |=> $stable(rdata))
    else $error("state moved while disabled");

  // Main scenarios
  write_read_c: cover property (wr_ok ##1 clk_en && rd);
  locked_write_c: cover property (clk_en && wr && hit && locked_hit);
  status_read_c: cover property (clk_en && rd && addr == `FTC_OT_STAT);

endmodule // ftc_regs

/* File: ftc_host.sv */
/*
  Host-side partner of the fan and thermal bank: one-cycle write and
  read strobes on the plain register port. Assumes the bench owns the
  clock and calls these tasks from one process only.
*/
`timescale 1ns/100ps

module ftc_host (
  input wire logic clk,
  input wire ftc_pkg::ftc_byte_t rdata,
  output ftc_pkg::ftc_addr_t addr,
  output ftc_pkg::ftc_byte_t wdata,
  output logic wr,
  output logic rd
);
  import ftc_pkg::*;

  // Quiet bus at time zero
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write cycle; factory test offsets are never touched
  task automatic write_reg(input ftc_addr_t a, input ftc_byte_t d);
    if (a >= 8'h7e && a <= 8'h80)
      return;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a; // Stale values would hide decode slips
    wdata <= ~d;
  endtask

  // Write then read back to back; test offsets get the read only
  task automatic write_read(input ftc_addr_t a, input ftc_byte_t d,
    output ftc_byte_t q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= !(a >= 8'h7e && a <= 8'h80);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1 q = rdata;
  endtask

  // One read cycle; data is taken in the cycle after the strobe
  task automatic read_reg(input ftc_addr_t a, output ftc_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1 d = rdata;
  endtask
endmodule // ftc_host

/* File: fan_thermal_config_regs_bench.sv */
/*
  Self-checking bench of the fan and thermal bank against an integer
  model. Assumes the host partner model and the bank's defaults.
*/
`timescale 1ns/100ps

module fan_thermal_config_regs_bench;
  import ftc_pkg::*;

  localparam logic [7:0] RST_TBL [39] = '{
    8'hff, 8'hff, 8'h82, 8'h82, 8'h82, 8'hcc, 8'hcc, 8'hcc, 8'h00, 8'h00,
    8'h80, 8'h80, 8'h80, 8'h9a, 8'h9a, 8'h9a, 8'ha4, 8'ha4, 8'ha4, 8'h44,
    8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10};

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic lock_bit = 1'b0;
  logic [1:0] msup = 2'h0, psup = 2'h0, r2l = 2'h0, locl = 2'h0;
  logic [1:0] r1l = 2'h0;
  logic [6:0] etimer = 7'h00;
  logic tflag = 1'b0;
  ftc_addr_t addr;
  ftc_byte_t wdata, rdata, drv1, evm1, cfg4, otlim;
  logic wr, rd, tree_on;
  logic [15:0] fan4_min;
  logic [3:0] r2hyst;
  int mismatches = 0;
  int samples_checked = 0;
  int mem [256];
  logic [31:0] seed = 32'he5af;

  always #50 clk = ~clk;

  ftc_host ftc_host_inst (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));

  ftc_regs ftc_regs_inst (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lock_bit(lock_bit),
    .main_supply_lsbs(msup), .processor_supply(psup),
    .remote2_lsbs(r2l), .local_lsbs(locl), .remote1_lsbs(r1l),
    .elapsed_timer(etimer), .asserted_timeout_flag(tflag),
    .fan4_speed_min(fan4_min), .fan_drive1_config(drv1),
    .fan_drive2_config(), .fan_drive3_config(),
    .remote1_range_drive_drive_code_a(), .local_range_drive_drive_code_a(),
    .remote2_range_drive_drive_code_a(), .acoustic_smoothing_1(),
    .acoustic_smoothing_2(), .drive1_min_duty(), .drive2_min_duty(),
    .drive3_min_duty(), .remote1_fan_start_temp(),
    .local_fan_start_temp(), .remote2_fan_start_temp(),
    .remote1_overtemp_limit(), .local_overtemp_limit(),
    .remote2_overtemp_limit(), .remote1_hyst(), .local_hyst(),
    .remote2_hyst(r2hyst), .logic_tree_test_on(tree_on),
    .remote1_temp_offset(), .local_temp_offset(),
    .remote2_temp_offset(), .config_two(), .event_mask_one(evm1),
    .event_mask_two(), .config_three(), .overtemp_timer_limit(otlim),
    .fan_pulses_per_rev(), .config_five(), .config_four(cfg4)
  );

  // Xorshift stream for write data and live inputs
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Bits a host write may change, given the lock state
  function automatic int wmask(input int a, input bit lk);
    if (a < 8'h5a || a > 8'h7d || a == 8'h76 || a == 8'h77 || a == 8'h79)
      return 0;
    if (lk && ((a >= 8'h5c && a <= 8'h73) || a == 8'h78 || a >= 8'h7c))
      return 0;
    case (a)
      8'h6e: return 8'hf0;
      8'h6f: return 8'h01;
      8'h74: return 8'hf6;
      8'h75: return 8'hfe;
      8'h7d: return 8'h3f;
      default: return 8'hff;
    endcase
  endfunction

  // Expected read value; live bytes come from the bench's inputs
  function automatic int expv(input int a);
    case (a)
      8'h76: return {msup, psup, 2'b00};
      8'h77: return {r2l, locl, r1l, 2'b00};
      8'h79: return {etimer, tflag};
      default: return mem[a];
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want,
    input string what);
    samples_checked++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic rd_chk(input int a);
    ftc_byte_t d;
    ftc_host_inst.read_reg(8'(a), d);
    check(16'(d), 16'(expv(a)), "read");
  endtask

  task automatic wr_mdl(input int a, input int d);
    int m;
    ftc_byte_t q;
    m = wmask(a, lock_bit);
    ftc_host_inst.write_read(8'(a), 8'(d), q);
    mem[a] = ((mem[a] & ~m) | (d & m)) & 8'hff;
    check(16'(q), 16'(expv(a)), "write read");
  endtask

  // Whole bank plus one unmapped offset on each side
  task automatic sweep;
    for (int a = 8'h59; a <= 8'h81; a++)
      rd_chk(a);
    check(fan4_min, 16'((mem[8'h5b] << 8) | mem[8'h5a]), "fan4");
    check(16'(drv1), 16'(mem[8'h5c]), "drv1");
    check(16'(r2hyst), 16'(mem[8'h6e] >> 4), "hyst");
    check(16'(tree_on), 16'(mem[8'h6f] & 1), "tree");
    check(16'(evm1), 16'(mem[8'h74]), "mask1");
    check(16'(otlim), 16'(mem[8'h7a]), "limit");
    check(16'(cfg4), 16'(mem[8'h7d]), "cfg4");
  endtask

  // Random data to every offset, test registers skipped by the host
  task automatic fill;
    for (int a = 8'h59; a <= 8'h81; a++)
    begin
      seed = xs(seed);
      wr_mdl(a, int'(seed[7:0]));
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #(20000 * 100);
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    for (int i = 0; i < 39; i++)
      mem[8'h5a + i] = RST_TBL[i];
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    sweep();
    $display("test reset_values done");
    fill();
    sweep();
    $display("test write_unlocked done");
    @(posedge clk);
    lock_bit <= 1'b1;
    fill();
    sweep();
    @(posedge clk);
    lock_bit <= 1'b0;
    $display("test write_locked done");
    // Live read-only bytes follow their inputs
    repeat (4)
    begin
      seed = xs(seed);
      @(posedge clk);
      {msup, psup, r2l, locl, r1l, etimer, tflag} <= seed[17:0];
      rd_chk(8'h76);
      rd_chk(8'h77);
      rd_chk(8'h79);
    end
    $display("test live_bytes done");
    // Read data stands one cycle only; a frozen clock drops writes
    rd_chk(8'h7a);
    @(posedge clk);
    #1 check(16'(rdata), 16'h0000, "rdata idle");
    clk_en <= 1'b0;
    ftc_host_inst.write_reg(8'h7a, 8'h5a);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(8'h7a);
    $display("test strobe_timing done");
    // Second reset in mid-run restores every default
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 39; i++)
      mem[8'h5a + i] = RST_TBL[i];
    sweep();
    $display("test second_reset done");
    stop_test();
  end
endmodule // fan_thermal_config_regs_bench
